/* File: verilog/fwh_consts.vh */
// Constants for the floating-point writeback and hazard control block
`ifndef FWH_CONSTS_VH
`define FWH_CONSTS_VH

// Register byte offsets
`define FWH_OFS_FSR        8'h00
`define FWH_OFS_IRQ_STAT   8'h04
`define FWH_OFS_IRQ_MASK   8'h08
`define FWH_OFS_STATUS     8'h0C

// Status register field positions
`define FWH_FSR_RND_HI     31
`define FWH_FSR_RND_LO     30
`define FWH_FSR_TEM_HI     27
`define FWH_FSR_TEM_LO     23
`define FWH_FSR_NS         22
`define FWH_FSR_VER_HI     19
`define FWH_FSR_VER_LO     17
`define FWH_FSR_FTT_HI     16
`define FWH_FSR_FTT_LO     14
`define FWH_FSR_QNE        13
`define FWH_FSR_FCC_HI     11
`define FWH_FSR_FCC_LO     10
`define FWH_FSR_AEXC_HI    9
`define FWH_FSR_AEXC_LO    5
`define FWH_FSR_CEXC_HI    4
`define FWH_FSR_CEXC_LO    0

// Bits that software may change in the status register
`define FWH_FSR_WR_MASK    32'hCFC00FFF
`define FWH_FSR_RESET      32'h00000000
// Version field value, arbitrary
`define FWH_FSR_VERSION    3'h5

// Rounding directions
`define FWH_RND_NEAREST    2'h0
`define FWH_RND_ZERO       2'h1
`define FWH_RND_POS_INF    2'h2
`define FWH_RND_NEG_INF    2'h3

// Trap type codes
`define FWH_FTT_NONE       3'h0
`define FWH_FTT_IEEE       3'h1
`define FWH_FTT_UNIMPL     3'h3

// Interrupt event bits
`define FWH_EV_UNIMPL      0
`define FWH_EV_IEEE        1
`define FWH_EV_ERROR       2
`define FWH_EV_DONE        3
`define FWH_EV_WIDTH       4

// NaN quiet bit and exponent positions
`define FWH_SGL_QBIT       22
`define FWH_SGL_EXP_HI     30
`define FWH_SGL_EXP_LO     23
`define FWH_DBL_QBIT       51
`define FWH_DBL_EXP_HI     62
`define FWH_DBL_EXP_LO     52

`endif

/* File: verilog/fwh_nan_quiet.v */
// Signaling NaN quieting on the result path
`default_nettype none
`include "fwh_consts.vh"

module fwh_nan_quiet (
  // Format and data
  input  wire        dbl,
  input  wire [63:0] data_in,
  output reg  [63:0] data_out
);

  wire sgl_signaling_nan;
  wire dbl_signaling_nan;

  assign sgl_signaling_nan = (&data_in[`FWH_SGL_EXP_HI:`FWH_SGL_EXP_LO]) &&
                             (|data_in[`FWH_SGL_QBIT-1:0]) && !data_in[`FWH_SGL_QBIT];
  assign dbl_signaling_nan = (&data_in[`FWH_DBL_EXP_HI:`FWH_DBL_EXP_LO]) &&
                             (|data_in[`FWH_DBL_QBIT-1:0]) && !data_in[`FWH_DBL_QBIT];

  // Only the quiet bit flips; quiet NaNs pass untouched
  always @* begin
    data_out = data_in;
    if (dbl && dbl_signaling_nan) begin
      data_out[`FWH_DBL_QBIT] = 1'b1;
    end else if (!dbl && sgl_signaling_nan) begin
      data_out[`FWH_SGL_QBIT] = 1'b1;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/fwh_ctrl.v */
// FP unit sequencing, register file write arbitration and status registers
//
// Chosen here: the register addresses and register access over AHB-Lite.
`default_nettype none
`include "fwh_consts.vh"

module fwh_ctrl (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  // Instruction issue from the integer pipeline
  input  wire        iss_valid,
  output wire        iss_ready,
  input  wire        iss_mul,
  input  wire        iss_dbl,
  input  wire        iss_ext,
  input  wire [4:0]  iss_rs1,
  input  wire [4:0]  iss_rs2,
  input  wire [4:0]  iss_rd,
  // Floating-point load data
  input  wire        ld_valid,
  output wire        ld_ready,
  input  wire        ld_dbl,
  input  wire [4:0]  ld_rd,
  input  wire [63:0] ld_data,
  // Floating-point store read toward the data cache
  input  wire        st_req,
  input  wire        st_dbl,
  input  wire [4:0]  st_rd,
  input  wire        st_dacc_exc,
  output reg         st_valid,
  output reg  [63:0] st_data,
  // Arithmetic datapath
  output reg         fp_adder_unit_start,
  output reg         fp_multiplier_unit_start,
  output wire [1:0]  round_mode,
  output reg  [63:0] op_a,
  output reg  [63:0] op_b,
  output reg         op_dbl,
  input  wire        res_valid,
  input  wire        res_exc,
  input  wire [63:0] res_data,
  // Events toward the integer unit
  output reg         fp_exc,
  output reg         error_mode,
  output wire        irq
);

  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_ADD  = 4'b0010;
  localparam [3:0] S_MUL  = 4'b0100;
  localparam [3:0] S_WB   = 4'b1000;

  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg  [31:0] rf [0:31];
  reg  [31:0] fsr;
  reg  [3:0]  irq_stat;
  reg  [3:0]  irq_mask;
  reg         ap_write;
  reg         ap_read;
  reg  [7:0]  ap_addr;
  reg  [4:0]  q_rd;
  reg         q_dbl;
  reg  [63:0] q_data;
  reg         q_full;
  reg  [31:0] rd_mux;

  wire        ap_take;
  wire [31:0] fsr_view;
  wire [4:0]  q_rd_e;
  wire [4:0]  ld_rd_e;
  wire [4:0]  st_rd_e;
  wire [4:0]  rs1_e;
  wire [4:0]  rs2_e;
  wire [4:0]  iss_rd_e;
  wire        wa_en;
  wire        wb_en;
  wire        dest_clash;
  wire        iss_take;
  wire        unimpl_ev;
  wire        ieee_ev;
  wire        exc_ev;
  wire        err_ev;
  wire        done_ev;
  wire [63:0] q_quiet;
  wire [3:0]  ev_vec;

  // Odd specifiers of double operands fold onto the even pair
  assign q_rd_e   = q_dbl   ? {q_rd[4:1], 1'b0}    : q_rd;
  assign ld_rd_e  = ld_dbl  ? {ld_rd[4:1], 1'b0}   : ld_rd;
  assign st_rd_e  = st_dbl  ? {st_rd[4:1], 1'b0}   : st_rd;
  assign rs1_e    = iss_dbl ? {iss_rs1[4:1], 1'b0} : iss_rs1;
  assign rs2_e    = iss_dbl ? {iss_rs2[4:1], 1'b0} : iss_rs2;
  assign iss_rd_e = iss_dbl ? {iss_rd[4:1], 1'b0}  : iss_rd;

  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ap_take   = hsel && hready && htrans[1];

  always @(posedge clk) begin
    if (!rst_n) begin
      ap_write <= 1'b0;
      ap_read  <= 1'b0;
      ap_addr  <= 8'h00;
    end else if (hready) begin
      ap_write <= ap_take && hwrite;
      ap_read  <= ap_take && !hwrite;
      ap_addr  <= haddr[7:0];
    end
  end

  assign fsr_view = {fsr[31:20], `FWH_FSR_VERSION, fsr[16:14], q_full, fsr[12:0]};

  always @* begin
    case (ap_addr)
      `FWH_OFS_FSR:      rd_mux = fsr_view;
      `FWH_OFS_IRQ_STAT: rd_mux = {28'h0000000, irq_stat};
      `FWH_OFS_IRQ_MASK: rd_mux = {28'h0000000, irq_mask};
      `FWH_OFS_STATUS:   rd_mux = {26'h0000000, error_mode, q_full, state};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  assign hrdata = ap_read ? rd_mux : 32'h00000000;

  // One operation at a time; issue waits until the queue has drained
  assign iss_ready = state[0];
  assign iss_take  = iss_valid && state[0];
  assign unimpl_ev = iss_take && iss_ext;
  assign ieee_ev   = (state[1] || state[2]) && res_valid && res_exc;
  assign done_ev   = (state[1] || state[2]) && res_valid && !res_exc;
  assign exc_ev    = unimpl_ev || ieee_ev;
  assign err_ev    = exc_ev && st_dacc_exc;

  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (iss_take && !iss_ext) begin
          next_state = iss_mul ? S_MUL : S_ADD;
        end
      end
      S_ADD, S_MUL: begin
        if (res_valid) begin
          next_state = res_exc ? S_IDLE : S_WB;
        end
      end
      S_WB:    next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state                    <= S_IDLE;
      fp_adder_unit_start      <= 1'b0;
      fp_multiplier_unit_start <= 1'b0;
      op_a                     <= 64'h0000000000000000;
      op_b                     <= 64'h0000000000000000;
      op_dbl                   <= 1'b0;
      q_rd                     <= 5'h00;
      q_dbl                    <= 1'b0;
      q_data                   <= 64'h0000000000000000;
      q_full                   <= 1'b0;
    end else begin
      state                    <= next_state;
      fp_adder_unit_start      <= iss_take && !iss_ext && !iss_mul;
      fp_multiplier_unit_start <= iss_take && !iss_ext && iss_mul;
      if (iss_take && !iss_ext) begin
        op_a   <= iss_dbl ? {rf[rs1_e], rf[rs1_e + 5'h01]} : {32'h00000000, rf[iss_rs1]};
        op_b   <= iss_dbl ? {rf[rs2_e], rf[rs2_e + 5'h01]} : {32'h00000000, rf[iss_rs2]};
        op_dbl <= iss_dbl;
        q_rd   <= iss_rd_e;
        q_dbl  <= iss_dbl;
      end
      // Single deferred entry holds the completed result until written
      if (done_ev) begin
        q_data <= res_data;
        q_full <= 1'b1;
      end else if (state[3]) begin
        q_full <= 1'b0;
      end
    end
  end

  fwh_nan_quiet u_nan_quiet (
    .dbl      (q_dbl),
    .data_in  (q_data),
    .data_out (q_quiet)
  );

  // Write arbitration between the queued result and an arriving load
  assign wa_en      = state[3];
  assign dest_clash = (q_dbl || ld_dbl) ? (q_rd_e[4:1] == ld_rd_e[4:1])
                                        : (q_rd_e == ld_rd_e);
  assign ld_ready   = !(wa_en && dest_clash);
  assign wb_en      = ld_valid && ld_ready;

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_rf
      wire hit_a_hi = wa_en && (q_rd_e == gi);
      wire hit_a_lo = wa_en && q_dbl && ({q_rd_e[4:1], 1'b1} == gi);
      wire hit_b_hi = wb_en && (ld_rd_e == gi);
      wire hit_b_lo = wb_en && ld_dbl && ({ld_rd_e[4:1], 1'b1} == gi);
      always @(posedge clk) begin
        if (!rst_n) begin
          rf[gi] <= 32'h00000000;
        end else if (hit_a_hi) begin
          rf[gi] <= q_dbl ? q_quiet[63:32] : q_quiet[31:0];
        end else if (hit_a_lo) begin
          rf[gi] <= q_quiet[31:0];
        end else if (hit_b_hi) begin
          rf[gi] <= ld_dbl ? ld_data[63:32] : ld_data[31:0];
        end else if (hit_b_lo) begin
          rf[gi] <= ld_data[31:0];
        end
      end
    end
  endgenerate

  // Store read uses the pre-write contents, independent of the write ports
  always @(posedge clk) begin
    if (!rst_n) begin
      st_valid <= 1'b0;
      st_data  <= 64'h0000000000000000;
    end else begin
      st_valid <= st_req;
      if (st_req) begin
        st_data <= st_dbl ? {rf[st_rd_e], rf[st_rd_e + 5'h01]}
                          : {32'h00000000, rf[st_rd]};
      end
    end
  end

  // Status register, exception and error tracking
  always @(posedge clk) begin
    if (!rst_n) begin
      fsr        <= `FWH_FSR_RESET;
      fp_exc     <= 1'b0;
      error_mode <= 1'b0;
    end else begin
      fp_exc <= exc_ev;
      if (err_ev) begin
        error_mode <= 1'b1;
      end
      if (ap_write && ap_addr == `FWH_OFS_FSR) begin
        fsr <= (hwdata & `FWH_FSR_WR_MASK) | (fsr & ~`FWH_FSR_WR_MASK);
      end
      if (unimpl_ev) begin
        fsr[`FWH_FSR_FTT_HI:`FWH_FSR_FTT_LO] <= `FWH_FTT_UNIMPL;
      end else if (ieee_ev) begin
        fsr[`FWH_FSR_FTT_HI:`FWH_FSR_FTT_LO] <= `FWH_FTT_IEEE;
      end else if (iss_take) begin
        fsr[`FWH_FSR_FTT_HI:`FWH_FSR_FTT_LO] <= `FWH_FTT_NONE;
      end
    end
  end

  assign round_mode = fsr[`FWH_FSR_RND_HI:`FWH_FSR_RND_LO];

  // Interrupt status: set wins over write-one-to-clear
  assign ev_vec = {done_ev, err_ev, ieee_ev, unimpl_ev};

  always @(posedge clk) begin
    if (!rst_n) begin
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
    end else begin
      if (ap_write && ap_addr == `FWH_OFS_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~hwdata[3:0]) | ev_vec;
      end else begin
        irq_stat <= irq_stat | ev_vec;
      end
      if (ap_write && ap_addr == `FWH_OFS_IRQ_MASK) begin
        irq_mask <= hwdata[3:0];
      end
    end
  end

  assign irq = |(irq_stat & irq_mask);

endmodule
`default_nettype wire

/* File: tb/fwh_checker.sv */
// Port checker for the fp writeback and hazard control block
`default_nettype none
module fwh_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Issue, load and store
  input wire logic iss_valid,
  input wire logic iss_ready,
  input wire logic iss_ext,
  input wire logic ld_ready,
  input wire logic st_req,
  input wire logic st_dacc_exc,
  input wire logic st_valid,
  // Datapath and events
  input wire logic fp_adder_unit_start,
  input wire logic fp_multiplier_unit_start,
  input wire logic fp_exc,
  input wire logic error_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  wire take = iss_valid & iss_ready;
  wire st   = fp_adder_unit_start | fp_multiplier_unit_start;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  one_unit_a: assert property (!(fp_adder_unit_start && fp_multiplier_unit_start))
    else $error("both units started");
  start_cause_a: assert property (st |-> $past(take && !iss_ext))
    else $error("start without issue");
  busy_refuse_a: assert property (st |-> !iss_ready)
    else $error("second op accepted");
  unimpl_trap_a: assert property (take && iss_ext |=> fp_exc && !st)
    else $error("unimplemented op not trapped");
  err_enter_a: assert property (take && iss_ext && st_dacc_exc |=> error_mode)
    else $error("error mode missed");
  err_hold_a: assert property (error_mode |=> error_mode)
    else $error("error mode dropped");
  ld_stall_a: assert property (!ld_ready |-> !iss_ready ##1 ld_ready)
    else $error("bad load stall");
  store_read_a: assert property (st_req |=> st_valid)
    else $error("store not answered");
  op_done_a: assert property (st |-> ##[2:40] iss_ready)
    else $error("op stuck");
  c_stall: cover property (!ld_ready);
  c_unimpl: cover property (take && iss_ext);
  c_mul: cover property (fp_multiplier_unit_start);
endmodule
bind fwh_ctrl fwh_checker chk_u (.*);
`default_nettype wire

/* File: tb/fwh_dp_model.sv */
// Datapath responder model: answers each start after a set latency
`default_nettype none
module fwh_dp_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Start and answer setup
  input  wire logic        start,
  input  wire logic [3:0]  lat,
  input  wire logic        exc,
  input  wire logic [63:0] val,
  // Completion
  output var  logic        res_valid,
  output var  logic        res_exc,
  output var  logic [63:0] res_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] cnt;
  always @(posedge clk) begin
    res_valid <= 1'h0;
    res_exc <= 1'h0;
    // Data only means something with res_valid
    res_data <= ~res_data;
    if (!rst_n) begin
      cnt <= 5'h0;
      res_data <= 64'h0;
    end else if (start) begin
      cnt <= {1'h0, lat};
    end else if (cnt != 5'h0) begin
      cnt <= cnt - 5'h1;
      if (cnt == 5'h1) begin
        res_valid <= 1'h1;
        res_exc <= exc;
        res_data <= val;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the fp writeback and hazard control block
`default_nettype none
`include "fwh_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic        op;
    logic        dbl;
    logic [4:0]  rd;
    logic [63:0] v;
    logic [63:0] e;
  } fwh_row_t;
  logic        clk = 1'h0, rst_n = 1'h0, hsel = 1'h1, hwrite = 1'h0;
  logic [2:0]  hsize = 3'h2;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, hrdata;
  logic        iss_valid = 1'h0, iss_mul = 1'h0, iss_dbl = 1'h0, iss_ext = 1'h0;
  logic [4:0]  iss_rs1 = 5'h0, iss_rs2 = 5'h0, iss_rd = 5'h0, ld_rd = 5'h0, st_rd = 5'h0;
  logic        ld_valid = 1'h0, ld_dbl = 1'h0, st_req = 1'h0, st_dbl = 1'h0;
  logic        st_dacc_exc = 1'h0, exc = 1'h0;
  logic [3:0]  lat = 4'h1;
  logic [63:0] ld_data = 64'h0, val = 64'h0, st_data, op_a, op_b, res_data;
  logic        hreadyout, hresp, iss_ready, ld_ready, st_valid, op_dbl, res_valid, res_exc;
  logic        fp_adder_unit_start, fp_multiplier_unit_start, fp_exc, error_mode, irq;
  logic [1:0]  round_mode;
  int          miscompares = 0, n_checks = 0, cyc = 0;
  fwh_row_t rows [7] = '{
    '{1'h0, 1'h0, 5'h03, 64'hAAAABBBB12345678, 64'h0000000012345678},
    '{1'h0, 1'h1, 5'h05, 64'h0123456789ABCDEF, 64'h0123456789ABCDEF},
    '{1'h0, 1'h1, 5'h08, 64'hFEDCBA9876543210, 64'hFEDCBA9876543210},
    '{1'h1, 1'h0, 5'h0C, 64'h000000007F800001, 64'h000000007FC00001},
    '{1'h1, 1'h0, 5'h0C, 64'h000000007FC00005, 64'h000000007FC00005},
    '{1'h1, 1'h1, 5'h0F, 64'h7FF0000000000001, 64'h7FF8000000000001},
    '{1'h1, 1'h1, 5'h0E, 64'h7FF8000000000002, 64'h7FF8000000000002}};
  fwh_ctrl dut_u (.hready(hreadyout), .*);
  fwh_dp_model dp_u (.start(fp_adder_unit_start | fp_multiplier_unit_start), .*);
  always #12.5 clk = ~clk;
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      $display("[ERR] %0t timeout", $time);
      conclude();
    end
  end
  task automatic chk(input logic [63:0] g, e, input string m);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  task automatic issue(input logic m, d, x, input logic [4:0] r);
    iss_valid <= 1'h1;
    iss_mul <= m;
    iss_dbl <= d;
    iss_ext <= x;
    iss_rs1 <= 5'h5;
    iss_rs2 <= 5'h9;
    iss_rd <= r;
    do @(posedge clk); while (iss_ready !== 1'h1);
    iss_valid <= 1'h0;
  endtask
  task automatic load(input logic d, input logic [4:0] r, input logic [63:0] v);
    ld_valid <= 1'h1;
    ld_dbl <= d;
    ld_rd <= r;
    ld_data <= v;
    do @(posedge clk); while (ld_ready !== 1'h1);
    ld_valid <= 1'h0;
  endtask
  task automatic idle();
    @(posedge clk);
    while (iss_ready !== 1'h1) @(posedge clk);
  endtask
  task automatic store(input logic d, input logic [4:0] r, input logic [63:0] e);
    st_req <= 1'h1;
    st_dbl <= d;
    st_rd <= r;
    @(posedge clk);
    st_req <= 1'h0;
    @(posedge clk);
    chk(st_valid, 1'h1, "st_valid");
    chk(st_data, e, "st_data");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    foreach (rows[i]) begin
      val <= rows[i].v;
      if (rows[i].op)
        issue(1'h1, rows[i].dbl, 1'h0, rows[i].rd);
      else
        load(rows[i].dbl, rows[i].rd, rows[i].v);
      idle();
      store(rows[i].dbl, rows[i].rd ^ {4'h0, rows[i].dbl}, rows[i].e);
    end
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, `FWH_OFS_FSR, {i[1:0], 30'h3FFFFFFF});
      bus(1'h0, `FWH_OFS_FSR, 32'h0);
      chk(round_mode, i[1:0], "round");
      chk(q, {i[1:0], 30'h0FC00FFF} | {12'h0, `FWH_FSR_VERSION, 17'h0}, "fsr");
    end
    lat <= 4'h6;
    val <= 64'h4000000000000001;
    issue(1'h0, 1'h1, 1'h0, 5'h3);
    @(posedge clk);
    chk(fp_adder_unit_start, 1'h1, "add");
    chk(fp_multiplier_unit_start, 1'h0, "mul");
    chk(op_a, rows[1].v, "op_a");
    chk(op_b, rows[2].v, "op_b");
    chk(op_dbl, 1'h1, "op_dbl");
    iss_valid <= 1'h1;
    @(posedge clk);
    chk(iss_ready, 1'h0, "busy");
    iss_valid <= 1'h0;
    idle();
    store(1'h1, 5'h2, 64'h4000000000000001);
    lat <= 4'h1;
    for (int j = 0; j < 2; j++) begin
      val <= 64'h11111111;
      issue(1'h0, 1'h0, 1'h0, 5'h14);
      while (res_valid !== 1'h1) @(posedge clk);
      ld_valid <= 1'h1;
      ld_dbl <= 1'h0;
      ld_rd <= j ? 5'h14 : 5'h15;
      ld_data <= 64'h22222222;
      @(posedge clk);
      chk(ld_ready, j == 0, "ld_ready");
      if (j)
        @(posedge clk);
      ld_valid <= 1'h0;
      store(1'h0, 5'h14, j ? 64'h22222222 : 64'h11111111);
      store(1'h0, 5'h15, 64'h22222222);
    end
    st_req <= 1'h1;
    st_rd <= 5'h14;
    load(1'h0, 5'h14, 64'h33333333);
    st_req <= 1'h0;
    @(posedge clk);
    chk(st_data, 64'h22222222, "old");
    store(1'h0, 5'h14, 64'h33333333);
    issue(1'h0, 1'h0, 1'h1, 5'h18);
    @(posedge clk);
    chk(fp_exc, 1'h1, "trap");
    chk(fp_adder_unit_start, 1'h0, "exec");
    chk(iss_ready, 1'h1, "idle");
    chk(error_mode, 1'h0, "err");
    bus(1'h0, `FWH_OFS_FSR, 32'h0);
    chk(q[16:14], `FWH_FTT_UNIMPL, "ftt");
    chk(irq, 1'h0, "masked");
    bus(1'h1, `FWH_OFS_IRQ_MASK, 32'h1);
    bus(1'h0, `FWH_OFS_IRQ_MASK, 32'h0);
    chk(q, 32'h1, "mask");
    bus(1'h0, `FWH_OFS_IRQ_STAT, 32'h0);
    chk(q, 32'h9, "stat");
    chk(irq, 1'h1, "irq");
    bus(1'h1, `FWH_OFS_IRQ_STAT, 32'hF);
    bus(1'h0, 32'h40, 32'h0);
    chk(q, 32'h0, "unmapped");
    chk(irq, 1'h0, "cleared");
    exc <= 1'h1;
    issue(1'h0, 1'h0, 1'h0, 5'h1A);
    while (res_valid !== 1'h1) @(posedge clk);
    @(posedge clk);
    chk(fp_exc, 1'h1, "ieee exc");
    chk(iss_ready, 1'h1, "ieee idle");
    exc <= 1'h0;
    bus(1'h0, `FWH_OFS_FSR, 32'h0);
    chk(q[16:14], `FWH_FTT_IEEE, "ftt ieee");
    chk(hresp, 1'h0, "okay");
    bus(1'h0, `FWH_OFS_IRQ_STAT, 32'h0);
    chk(q, 32'h2, "stat ieee");
    chk(irq, 1'h0, "masked ieee");
    store(1'h0, 5'h1A, 64'h0);
    st_dacc_exc <= 1'h1;
    issue(1'h0, 1'h0, 1'h1, 5'h18);
    st_dacc_exc <= 1'h0;
    @(posedge clk);
    chk(error_mode, 1'h1, "err");
    bus(1'h0, `FWH_OFS_STATUS, 32'h0);
    chk(q, 32'h21, "status");
    chk(irq, 1'h1, "irq again");
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    chk(error_mode, 1'h0, "reset");
    chk(irq, 1'h0, "reset irq");
    chk(iss_ready, 1'h1, "reset idle");
    chk(ld_ready, 1'h1, "reset ld");
    store(1'h0, 5'h14, 64'h0);
    conclude();
  end
endmodule
`default_nettype wire
